// >>> verilog/cmp_ctrl_params.svh
// register offsets, field positions and reset values of the comparator control block
`ifndef CMP_CTRL_PARAMS_SVH
`define CMP_CTRL_PARAMS_SVH

`define ADDR_W 12
`define OFS_MASKED_IRQ_FLAGS 12'h000
`define OFS_RAW_IRQ_FLAGS 12'h004
`define OFS_IRQ_ENABLE_MASK 12'h008
`define OFS_REFERENCE_CONTROL 12'h010
`define OFS_STATE_0 12'h020
`define OFS_CONTROL_0 12'h024
`define OFS_STATE_1 12'h040
`define OFS_CONTROL_1 12'h044

// reference control fields
`define REF_EN_BIT 9
`define REF_RANGE_BIT 8
`define REF_TAP_MSB 3
`define REF_RESET 6'h00

// comparator control fields
`define CTL_PIN_EN_BIT 11
`define CTL_SRC_MSB 10
`define CTL_SRC_LSB 9
`define CTL_TRG_LVL_BIT 7
`define CTL_TRG_SENSE_MSB 6
`define CTL_TRG_SENSE_LSB 5
`define CTL_IRQ_LVL_BIT 4
`define CTL_IRQ_SENSE_MSB 3
`define CTL_IRQ_SENSE_LSB 2
`define CTL_INVERT_BIT 1
`define CTL_RESET 10'h000

// state register field
`define STATE_LEVEL_BIT 1

`endif

// >>> verilog/cmp_ctrl_pkg.sv
// types shared by the comparator control block
package cmp_ctrl_pkg;
    typedef enum logic [1:0] {
        SENSE_LEVEL,
        SENSE_FALL,
        SENSE_RISE,
        SENSE_BOTH
    } sense_t;

    typedef enum logic [1:0] {
        SRC_OWN_PIN,
        SRC_CMP0_PIN,
        SRC_INTERNAL_REF,
        SRC_RESERVED
    } source_t;

    typedef struct packed {
        logic pin_enable;
        source_t positive_source_select;
        logic trigger_level;
        sense_t trigger_sense;
        logic irq_level;
        sense_t irq_sense;
        logic invert;
    } comparator_control_t;

    typedef struct packed {
        logic enable;
        logic ladder_range;
        logic [3:0] tap;
    } reference_control_t;
endpackage : cmp_ctrl_pkg

// >>> verilog/analog_comparator_control.sv
// digital control around two analog comparators: bus registers, edge logic, routing
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "cmp_ctrl_params.svh"

module analog_comparator_control
    import cmp_ctrl_pkg::*;
#(
    parameter int NUM_CMP = 2
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [`ADDR_W-1:0] bus_addr_in,
    input wire logic [31:0] bus_wdata_in,
    input wire logic bus_write_in,
    input wire logic bus_read_in,
    output logic [31:0] bus_rdata_out,
    input wire logic [NUM_CMP-1:0] compare_raw_in,
    input wire logic [NUM_CMP-1:0] gpio_alt_select_in,
    input wire logic [NUM_CMP-1:0] gpio_data_in,
    output logic [NUM_CMP-1:0] pin_data_out,
    output logic [NUM_CMP-1:0] adc_trigger_out,
    output logic irq_out,
    output logic [2*NUM_CMP-1:0] positive_source_select_out,
    output logic ref_enable_out,
    output logic ref_ladder_range_out,
    output logic [3:0] ref_tap_out
);

    // edge/level event decode shared by interrupt and trigger paths
    function automatic logic sense_hit(input sense_t sense, input logic lvl,
                                       input logic now, input logic prev);
        case (sense)
            SENSE_LEVEL: sense_hit = (now == lvl);
            SENSE_FALL: sense_hit = prev & ~now;
            SENSE_RISE: sense_hit = ~prev & now;
            SENSE_BOTH: sense_hit = prev ^ now;
            default: sense_hit = 1'b0;
        endcase
    endfunction : sense_hit

    function automatic comparator_control_t unpack_ctl(input logic [31:0] d);
        unpack_ctl.pin_enable = d[`CTL_PIN_EN_BIT];
        unpack_ctl.positive_source_select = source_t'(d[`CTL_SRC_MSB:`CTL_SRC_LSB]);
        unpack_ctl.trigger_level = d[`CTL_TRG_LVL_BIT];
        unpack_ctl.trigger_sense = sense_t'(d[`CTL_TRG_SENSE_MSB:`CTL_TRG_SENSE_LSB]);
        unpack_ctl.irq_level = d[`CTL_IRQ_LVL_BIT];
        unpack_ctl.irq_sense = sense_t'(d[`CTL_IRQ_SENSE_MSB:`CTL_IRQ_SENSE_LSB]);
        unpack_ctl.invert = d[`CTL_INVERT_BIT];
    endfunction : unpack_ctl

    function automatic logic [31:0] pack_ctl(input comparator_control_t c);
        pack_ctl = 32'h0000_0000;
        pack_ctl[`CTL_PIN_EN_BIT] = c.pin_enable;
        pack_ctl[`CTL_SRC_MSB:`CTL_SRC_LSB] = c.positive_source_select;
        pack_ctl[`CTL_TRG_LVL_BIT] = c.trigger_level;
        pack_ctl[`CTL_TRG_SENSE_MSB:`CTL_TRG_SENSE_LSB] = c.trigger_sense;
        pack_ctl[`CTL_IRQ_LVL_BIT] = c.irq_level;
        pack_ctl[`CTL_IRQ_SENSE_MSB:`CTL_IRQ_SENSE_LSB] = c.irq_sense;
        pack_ctl[`CTL_INVERT_BIT] = c.invert;
    endfunction : pack_ctl

    // register file
    comparator_control_t ctl_r [NUM_CMP];
    reference_control_t ref_r;
    logic [NUM_CMP-1:0] irq_en_r;
    logic [NUM_CMP-1:0] raw_r;
    logic [NUM_CMP-1:0] raw_nxt;
    logic [31:0] rdata_nxt;

    // comparator result path
    logic [NUM_CMP-1:0] sync1_r;
    logic [NUM_CMP-1:0] sync2_r;
    logic [NUM_CMP-1:0] level_r;
    logic [NUM_CMP-1:0] prev_r;
    logic [NUM_CMP-1:0] level_nxt;
    logic [NUM_CMP-1:0] irq_hit;
    logic [NUM_CMP-1:0] trg_hit;
    logic [NUM_CMP-1:0] pin_nxt;
    logic [NUM_CMP-1:0] masked;
    logic [2*NUM_CMP-1:0] src_nxt;

    wire logic wr_masked = bus_write_in && (bus_addr_in == `OFS_MASKED_IRQ_FLAGS);
    wire logic wr_enable = bus_write_in && (bus_addr_in == `OFS_IRQ_ENABLE_MASK);
    wire logic wr_ref = bus_write_in && (bus_addr_in == `OFS_REFERENCE_CONTROL);
    wire logic [NUM_CMP-1:0] clear_req = wr_masked ? bus_wdata_in[NUM_CMP-1:0] : '0;
    wire logic [`ADDR_W-1:0] ofs_ctl [NUM_CMP] = '{`OFS_CONTROL_0, `OFS_CONTROL_1};
    wire logic [`ADDR_W-1:0] ofs_state [NUM_CMP] = '{`OFS_STATE_0, `OFS_STATE_1};

    assign masked = raw_r & irq_en_r;

    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : gen_cmp
            // core already reports one when negative sits below positive
            // inversion ahead of every consumer keeps them consistent
            assign level_nxt[g] = sync2_r[g] ^ ctl_r[g].invert;
            // separate sense settings per path
            assign irq_hit[g] = sense_hit(ctl_r[g].irq_sense, ctl_r[g].irq_level,
                                          level_r[g], prev_r[g]);
            assign trg_hit[g] = sense_hit(ctl_r[g].trigger_sense, ctl_r[g].trigger_level,
                                          level_r[g], prev_r[g]);
            // a new event beats a same-cycle clear
            assign raw_nxt[g] = irq_hit[g] | (raw_r[g] & ~clear_req[g]);
            // gpio data until the alternate function and pin drive are chosen
            assign pin_nxt[g] = (gpio_alt_select_in[g] && ctl_r[g].pin_enable) ?
                                level_r[g] : gpio_data_in[g];
            // analog mux select for the positive input
            assign src_nxt[2*g+1:2*g] = ctl_r[g].positive_source_select;

            always_ff @(posedge clk_sys_in or posedge reset_in) begin
                if (reset_in) begin
                    ctl_r[g] <= comparator_control_t'(`CTL_RESET);
                end else if (bus_write_in && bus_addr_in == ofs_ctl[g]) begin
                    ctl_r[g] <= unpack_ctl(bus_wdata_in);
                end
            end
        end
    endgenerate

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (bus_read_in) begin
            case (bus_addr_in)
                `OFS_MASKED_IRQ_FLAGS: rdata_nxt[NUM_CMP-1:0] = masked;
                `OFS_RAW_IRQ_FLAGS: rdata_nxt[NUM_CMP-1:0] = raw_r;
                `OFS_IRQ_ENABLE_MASK: rdata_nxt[NUM_CMP-1:0] = irq_en_r;
                `OFS_REFERENCE_CONTROL: begin
                    rdata_nxt[`REF_EN_BIT] = ref_r.enable;
                    rdata_nxt[`REF_RANGE_BIT] = ref_r.ladder_range;
                    rdata_nxt[`REF_TAP_MSB:0] = ref_r.tap;
                end
                default: begin
                    for (int i = 0; i < NUM_CMP; i++) begin
                        if (bus_addr_in == ofs_ctl[i]) begin
                            rdata_nxt = pack_ctl(ctl_r[i]);
                        end
                        if (bus_addr_in == ofs_state[i]) begin
                            rdata_nxt[`STATE_LEVEL_BIT] = level_r[i];
                        end
                    end
                end
            endcase
        end
    end

    // two flops before anything looks at the analog result
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
            level_r <= '0;
            prev_r <= '0;
        end else begin
            sync1_r <= compare_raw_in;
            sync2_r <= sync1_r;
            level_r <= level_nxt;
            prev_r <= level_r;
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            raw_r <= '0;
            irq_en_r <= '0;
        end else begin
            raw_r <= raw_nxt;
            if (wr_enable) begin
                irq_en_r <= bus_wdata_in[NUM_CMP-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            ref_r <= reference_control_t'(`REF_RESET);
        end else if (wr_ref) begin
            ref_r.enable <= bus_wdata_in[`REF_EN_BIT];
            ref_r.ladder_range <= bus_wdata_in[`REF_RANGE_BIT];
            ref_r.tap <= bus_wdata_in[`REF_TAP_MSB:0];
        end
    end

    // ladder drive; tap forced to ground while disabled
    // range picks the 31R (tap+8) or 23R (tap) ladder
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            ref_enable_out <= 1'b0;
            ref_ladder_range_out <= 1'b0;
            ref_tap_out <= 4'h0;
        end else begin
            ref_enable_out <= ref_r.enable;
            ref_ladder_range_out <= ref_r.ladder_range;
            ref_tap_out <= ref_r.enable ? ref_r.tap : 4'h0;
        end
    end

    // outputs, each straight from a flop; costs one cycle of latency
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            bus_rdata_out <= 32'h0000_0000;
            pin_data_out <= '0;
            adc_trigger_out <= '0;
            irq_out <= 1'b0;
            positive_source_select_out <= '0;
        end else begin
            bus_rdata_out <= rdata_nxt;
            pin_data_out <= pin_nxt;
            adc_trigger_out <= trg_hit;
            irq_out <= |(raw_nxt & irq_en_r);
            positive_source_select_out <= src_nxt;
        end
    end

endmodule : analog_comparator_control
`default_nettype wire

// >>> dv/cmp_ctrl_props.sv
// bound checker on the comparator control ports
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl_props #(
    parameter int NUM_CMP = 2
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [11:0] bus_addr_in,
    input wire logic [31:0] bus_wdata_in,
    input wire logic bus_write_in,
    input wire logic bus_read_in,
    input wire logic [31:0] bus_rdata_out,
    input wire logic irq_out,
    input wire logic [2*NUM_CMP-1:0] positive_source_select_out,
    input wire logic ref_enable_out,
    input wire logic ref_ladder_range_out,
    input wire logic [3:0] ref_tap_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);
    sequence s_wr_mask; bus_write_in && bus_addr_in == 12'h008; endsequence
    sequence s_rd_mask; bus_read_in && bus_addr_in == 12'h008; endsequence
    property p_rd_idle; !bus_read_in |=> bus_rdata_out == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_readback;
        s_wr_mask ##1 !bus_write_in ##1 s_rd_mask |=>
            bus_rdata_out == {30'h0, $past(bus_wdata_in[1:0], 3)};
    endproperty
    a_readback: assert property (p_readback) else $error("mask readback");
    property p_unmapped; bus_read_in && bus_addr_in == 12'h0FC |=> bus_rdata_out == 0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_tap_gnd; !ref_enable_out |-> ref_tap_out == 4'h0; endproperty
    a_tap_gnd: assert property (p_tap_gnd) else $error("tap not grounded");
    // register then output flop: ladder and mux outputs follow a write two edges later
    property p_ref_wr;
        bus_write_in && bus_addr_in == 12'h010 |-> ##2
            ref_enable_out == $past(bus_wdata_in[9], 2)
            && ref_ladder_range_out == $past(bus_wdata_in[8], 2)
            && ref_tap_out == ($past(bus_wdata_in[9], 2) ? $past(bus_wdata_in[3:0], 2) : 4'h0);
    endproperty
    a_ref_wr: assert property (p_ref_wr) else $error("ladder outputs");
    property p_src0; bus_write_in && bus_addr_in == 12'h024 |-> ##2
        positive_source_select_out[1:0] == $past(bus_wdata_in[10:9], 2); endproperty
    a_src0: assert property (p_src0) else $error("source 0");
    property p_src1; bus_write_in && bus_addr_in == 12'h044 |-> ##2
        positive_source_select_out[3:2] == $past(bus_wdata_in[10:9], 2); endproperty
    a_src1: assert property (p_src1) else $error("source 1");
    property p_irq_off;
        bus_write_in && bus_addr_in == 12'h008 && bus_wdata_in[1:0] == 2'h0 |-> ##2 !irq_out;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq not masked");
endmodule : cmp_ctrl_props
bind analog_comparator_control cmp_ctrl_props #(.NUM_CMP(NUM_CMP)) cmp_ctrl_props_i (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .bus_addr_in(bus_addr_in),
    .bus_wdata_in(bus_wdata_in), .bus_write_in(bus_write_in), .bus_read_in(bus_read_in),
    .bus_rdata_out(bus_rdata_out), .irq_out(irq_out),
    .positive_source_select_out(positive_source_select_out), .ref_enable_out(ref_enable_out),
    .ref_ladder_range_out(ref_ladder_range_out), .ref_tap_out(ref_tap_out));
`default_nettype wire

// >>> dv/cmp_core_model.sv
// behavioural comparator cores, input pins and resistor ladder
`timescale 1ns/1ps
`default_nettype none
module cmp_core_model (
    input wire logic [3:0] source_in,
    input wire logic ref_en_in,
    input wire logic ref_range_in,
    input wire logic [3:0] ref_tap_in,
    input var int neg0_in,
    input var int neg1_in,
    input var int pos0_in,
    input var int pos1_in,
    output logic [1:0] result_out
);
    // millivolts on a 3300 mV supply, integer steps are close enough
    int vref;
    assign vref = !ref_en_in ? 0 : ref_range_in ? ref_tap_in * 3300 / 23
        : (ref_tap_in + 8) * 3300 / 31;
    function automatic int pick(input logic [1:0] s, input int own, input int p0, input int r);
        return s == 2'h0 ? own : s == 2'h1 ? p0 : r;
    endfunction : pick
    assign result_out[0] = neg0_in < pick(source_in[1:0], pos0_in, pos0_in, vref);
    assign result_out[1] = neg1_in < pick(source_in[3:2], pos1_in, pos0_in, vref);
endmodule : cmp_core_model
`default_nettype wire

// >>> dv/tb_analog_comparator_control.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module tb_analog_comparator_control;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic [11:0] bus_addr_in = 12'h000;
    logic [31:0] bus_wdata_in = 32'h0;
    logic bus_write_in = 1'b0;
    logic bus_read_in = 1'b0;
    logic [1:0] gpio_alt_select_in = 2'h0;
    logic [1:0] gpio_data_in = 2'h0;
    logic [31:0] bus_rdata_out;
    logic [1:0] raw, pin_data_out, adc_trigger_out;
    logic irq_out, ref_enable_out, ref_ladder_range_out;
    logic [3:0] positive_source_select_out, ref_tap_out;
    int neg0 = 2000;
    int neg1 = 2000;
    int pos0 = 1500;
    int pos1 = 1500;
    int failures = 0;
    int cmp_count = 0;
    logic [11:0] ofs [9] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h020, 12'h024, 12'h040,
        12'h044, 12'h0FC};
    analog_comparator_control #(.NUM_CMP(2)) analog_comparator_control_i (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .bus_addr_in(bus_addr_in),
        .bus_wdata_in(bus_wdata_in), .bus_write_in(bus_write_in), .bus_read_in(bus_read_in),
        .bus_rdata_out(bus_rdata_out), .compare_raw_in(raw),
        .gpio_alt_select_in(gpio_alt_select_in), .gpio_data_in(gpio_data_in),
        .pin_data_out(pin_data_out), .adc_trigger_out(adc_trigger_out), .irq_out(irq_out),
        .positive_source_select_out(positive_source_select_out),
        .ref_enable_out(ref_enable_out), .ref_ladder_range_out(ref_ladder_range_out),
        .ref_tap_out(ref_tap_out));
    cmp_core_model cmp_core_model_i (.source_in(positive_source_select_out),
        .ref_en_in(ref_enable_out), .ref_range_in(ref_ladder_range_out), .ref_tap_in(ref_tap_out),
        .neg0_in(neg0), .neg1_in(neg1), .pos0_in(pos0), .pos1_in(pos1), .result_out(raw));
    initial forever #5 clk_sys_in = ~clk_sys_in;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : tick
    // one bus cycle; a read compares the word standing in the following cycle
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        bus_addr_in <= a;
        if (w) bus_wdata_in <= d;
        bus_write_in <= w;
        bus_read_in <= !w;
        @(posedge clk_sys_in);
        bus_write_in <= 1'b0;
        bus_read_in <= 1'b0;
        #1;
        if (!w) chk(bus_rdata_out, d);
    endtask : acc
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    task automatic wait_trig();
        int k;
        for (k = 0; k < 8 && adc_trigger_out[1] !== 1'b1; k++) tick(1);
        if (k == 8) begin
            failures++;
            print_verdict();
        end
    endtask : wait_trig
    initial begin
        repeat (8) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        // reset control senses a low level, so both raw flags set at once
        foreach (ofs[i]) acc(1'b0, ofs[i], (ofs[i] == 12'h004) ? 32'h3 : 32'h0);
        acc(1'b1, 12'h008, 32'h3);
        acc(1'b0, 12'h008, 32'h3);
        acc(1'b1, 12'h004, 32'h0);
        acc(1'b0, 12'h004, 32'h3);
        acc(1'b1, 12'h010, 32'h30C);
        tick(1);
        chk({ref_enable_out, ref_ladder_range_out, ref_tap_out}, 32'h3C);
        acc(1'b0, 12'h010, 32'h30C);
        acc(1'b1, 12'h024, 32'h40C);
        acc(1'b0, 12'h024, 32'h40C);
        @(posedge clk_sys_in) neg0 <= 1000;
        tick(6);
        acc(1'b0, 12'h020, 32'h2);
        // range zero keeps eight taps of offset: about 851 mV, below the input
        acc(1'b1, 12'h010, 32'h200);
        tick(6);
        acc(1'b0, 12'h020, 32'h0);
        acc(1'b1, 12'h010, 32'h30C);
        tick(6);
        acc(1'b0, 12'h020, 32'h2);
        acc(1'b0, 12'h000, 32'h3);
        chk(irq_out, 1'b1);
        acc(1'b1, 12'h000, 32'h0);
        acc(1'b0, 12'h000, 32'h3);
        // comparator 1 is still level sensed, so only bit 0 stays clear
        acc(1'b1, 12'h000, 32'h1);
        acc(1'b0, 12'h004, 32'h2);
        acc(1'b1, 12'h044, 32'h008);
        acc(1'b1, 12'h000, 32'h2);
        acc(1'b0, 12'h004, 32'h0);
        chk(irq_out, 1'b0);
        acc(1'b1, 12'h010, 32'h0FF);
        tick(1);
        chk(ref_tap_out, 4'h0);
        tick(6);
        acc(1'b0, 12'h020, 32'h0);
        acc(1'b1, 12'h010, 32'h100);
        tick(1);
        chk({ref_enable_out, ref_ladder_range_out, ref_tap_out}, 32'h10);
        acc(1'b1, 12'h008, 32'h0);
        acc(1'b0, 12'h000, 32'h0);
        acc(1'b0, 12'h004, 32'h1);
        acc(1'b1, 12'h008, 32'h3);
        tick(1);
        chk(irq_out, 1'b1);
        acc(1'b1, 12'h024, 32'h40E);
        tick(6);
        acc(1'b0, 12'h020, 32'h2);
        @(posedge clk_sys_in);
        gpio_alt_select_in <= 2'h2;
        gpio_data_in <= 2'h3;
        tick(2);
        chk(pin_data_out, 2'h3);
        // pin on, trigger on rising, interrupt on falling
        acc(1'b1, 12'h044, 32'h844);
        tick(6);
        chk(pin_data_out, 2'h1);
        acc(1'b1, 12'h000, 32'h3);
        @(posedge clk_sys_in) neg1 <= 1000;
        wait_trig();
        tick(1);
        chk({pin_data_out, adc_trigger_out[1]}, 3'h6);
        acc(1'b0, 12'h004, 32'h0);
        @(posedge clk_sys_in) neg1 <= 2000;
        tick(6);
        acc(1'b0, 12'h004, 32'h2);
        acc(1'b1, 12'h044, 32'h200);
        @(posedge clk_sys_in) pos0 <= 2500;
        tick(6);
        acc(1'b0, 12'h040, 32'h2);
        chk(positive_source_select_out, 4'h6);
        print_verdict();
    end
endmodule : tb_analog_comparator_control
`default_nettype wire
